// ==== dv/sram_pins_props.sv ====
// Pin-level checks between the SRAM and its controller.
// Assumes one clock; signals come straight from the joining interface.
`timescale 1ns/100ps
module sram_pins_props
  import sram_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic advance_load_n,
  input wire logic chip_en_n,
  input wire logic write_n,
  input wire logic [BYTES-1:0] byte_wr_n,
  input wire logic clk_en_n,
  input wire logic out_en_n,
  input wire logic output_register_select,
  input wire logic sleep_request,
  input wire logic [DATA_W-1:0] dq_from_ram,
  input wire logic dq_ctrl_oe_n,
  input wire logic dq_ram_oe_n
);
  logic load_sel;
  logic wr_now;
  assign load_sel = !clk_en_n && !chip_en_n && !advance_load_n
    && !sleep_request;
  // Write abort (no byte lanes) carries no data
  assign wr_now = !chip_en_n && !write_n && byte_wr_n != 2'h3;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // --------
  // Commands
  // --------
  sequence rd_cmd;
    load_sel && write_n && !out_en_n;
  endsequence
  sequence wr_cmd;
    load_sel && wr_now;
  endsequence

  chk_rd_pipe_lat:
    assert property (rd_cmd ##0 output_register_select
      |-> ##2 !dq_ram_oe_n) else $error("pipelined read data late");
  chk_rd_flow_lat:
    assert property (rd_cmd ##0 !output_register_select
      |-> ##1 !dq_ram_oe_n) else $error("flow read data late");
  chk_wr_pipe_data:
    assert property (wr_cmd ##0 output_register_select
      |-> ##2 !dq_ctrl_oe_n) else $error("pipelined write data missing");
  chk_wr_flow_data:
    assert property (wr_cmd ##0 !output_register_select
      |-> ##1 !dq_ctrl_oe_n) else $error("flow write data missing");
  chk_sleep_outputs_off:
    assert property (sleep_request [*6] |-> dq_ram_oe_n)
      else $error("outputs driven while asleep");
  chk_wake_no_write:
    assert property ($fell(sleep_request) |-> !wr_now [*4])
      else $error("write during wake-up");
  chk_sleep_drained:
    assert property ($rose(sleep_request)
      |-> !$past(wr_now) && !$past(wr_now, 2))
      else $error("sleep raised with write pending");
  chk_hold_freeze:
    assert property (clk_en_n && $past(clk_en_n) && $stable(sleep_request)
      && $stable(out_en_n) |-> $stable(dq_ram_oe_n)
      && (dq_ram_oe_n || $stable(dq_from_ram)))
      else $error("data moved during hold");
  chk_upper_held:
    assert property (load_sel ##1 advance_load_n && !clk_en_n
      |-> addr[ADDR_W-1:2] == $past(addr[ADDR_W-1:2]))
      else $error("upper address moved in burst");
  chk_reset_state:
    assert property ($rose(presetn) |-> output_register_select
      && !sleep_request && dq_ram_oe_n) else $error("bad reset state");
endmodule

// ==== dv/sync_sram_burst_sleep_ctrl_tb.sv ====
// Self-checking bench: APB drives the controller, which drives the SRAM.
// Assumes the pair shares pclk; read beats are watched on the pins.
`timescale 1ns/100ps
module sync_sram_burst_sleep_ctrl_tb
  import sram_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] q;
  logic e;
  logic [15:0] beats[$];
  int fails;
  int samples_checked;

  sram_if pins ();
  sram_dev u_sram_dev (.pclk(pclk), .presetn(presetn), .pins(pins));
  sram_ctrl u_sram_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins));
  sram_pins_props u_sram_pins_props (.pclk(pclk), .presetn(presetn),
    .addr(pins.addr), .advance_load_n(pins.advance_load_n),
    .chip_en_n(pins.chip_en_n), .write_n(pins.write_n),
    .byte_wr_n(pins.byte_wr_n), .clk_en_n(pins.clk_en_n),
    .out_en_n(pins.out_en_n),
    .output_register_select(pins.output_register_select),
    .sleep_request(pins.sleep_request), .dq_from_ram(pins.dq_from_ram),
    .dq_ctrl_oe_n(pins.dq_ctrl_oe_n), .dq_ram_oe_n(pins.dq_ram_oe_n));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Every driven beat is kept, so order and count are both seen
  always @(posedge pclk) begin
    if (presetn === 1'b1 && pins.dq_ram_oe_n === 1'b0)
      beats.push_back(pins.dq_from_ram);
  end

  // --------
  // Tasks
  // --------
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One memory command, waited out; leaves the read word in q
  task automatic op(input logic w, input logic b, input logic [1:0] be,
    input logic [7:0] ad, input logic [15:0] d);
    apb(1'b1, WDATA_OFS, {16'h0, d});
    apb(1'b1, CMD_OFS, {1'b1, w, b, 11'h0, be, 8'h0, ad});
    do begin
      apb(1'b0, STATUS_OFS, 32'h0);
    end while (q[0] !== 1'b0);
    apb(1'b0, RDATA_OFS, 32'h0);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    fails++;
    end_of_test();
  end

  // --------
  // Tests
  // --------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fails = 0;
    samples_checked = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CFG_OFS, 32'h0);
    chk_data(q[15:0], {12'h0, CFG_RESET});
    apb(1'b0, 8'h14, 32'h0);
    chk_flag(e, 1'b1);
    // Modes 2,3,0,1: pipeline/flow with linear/interleave from start 01
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, CFG_OFS, {30'h0, m[1:0] ^ 2'h2});
      for (int k = 0; k < 4; k++)
        op(1'b1, 1'b0, 2'h3, 8'h20 + k[7:0], 16'ha000 + 16'(m * 16 + k));
      beats.delete();
      op(1'b0, 1'b1, 2'h0, 8'h21, 16'h0);
      chk_data(16'(beats.size()), 16'h4);
      for (int k = 0; k < 4; k++)
        chk_data(beats[k], 16'ha000 + 16'(m * 16 +
          (m[0] ? 1 ^ k : (1 + k) % 4)));
    end
    op(1'b1, 1'b0, 2'h3, 8'h40, 16'h1234);
    op(1'b1, 1'b0, 2'h1, 8'h40, 16'habcd);
    op(1'b1, 1'b0, 2'h0, 8'h40, 16'hffff);
    op(1'b0, 1'b0, 2'h0, 8'h40, 16'h0);
    chk_data(q[15:0], 16'h12cd);
    // A different word in the read register shows a stale result
    op(1'b0, 1'b0, 2'h0, 8'h20, 16'h0);
    apb(1'b1, CFG_OFS, 32'h6);
    repeat (12) @(posedge pclk);
    chk_flag(pins.sleep_request, 1'b1);
    chk_flag(pins.dq_ram_oe_n, 1'b1);
    apb(1'b1, CFG_OFS, 32'h2);
    op(1'b0, 1'b0, 2'h0, 8'h40, 16'h0);
    chk_data(q[15:0], 16'h12cd);
    apb(1'b1, CFG_OFS, 32'ha);
    repeat (4) @(posedge pclk);
    chk_flag(pins.clk_en_n, 1'b1);
    apb(1'b1, CFG_OFS, 32'h2);
    op(1'b0, 1'b0, 2'h0, 8'h23, 16'h0);
    chk_data(q[15:0], 16'ha033);
    end_of_test();
  end
endmodule

// ==== hdl/burst_addr_gen.sv ====
// Two-bit burst address generator for the low address bits.
// Assumes load and step are already qualified by clock enable.
`timescale 1ns/100ps
module burst_addr_gen
  import sram_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic step,
  input wire logic interleave,
  input wire logic [1:0] start,
  output logic [1:0] addr_lo
);
  logic [1:0] start_reg;
  logic [1:0] cnt_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_reg <= 2'h0;
      cnt_reg <= BURST_START_CNT;
    end else if (load) begin
      start_reg <= start;
      // The load beat uses the pin address, so the first continue
      // must already show the next one
      cnt_reg <= BURST_START_CNT + 2'h1;
    end else if (step) begin
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  always_comb begin
    if (interleave) begin
      addr_lo = start_reg ^ cnt_reg;
    end else begin
      addr_lo = start_reg + cnt_reg;
    end
  end
endmodule

// ==== hdl/sram_ctrl.sv ====
// SRAM controller end: APB registers drive single or burst accesses.
// Assumes the SRAM pins share pclk; data returns after fixed latency.
`timescale 1ns/100ps
module sram_ctrl
  import sram_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  sram_if.ctrl pins
);
  logic [3:0] cfg_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic busy_reg;
  logic [1:0] left_reg;
  logic is_wr_reg;
  logic [3:0] dly_reg;
  logic [3:0] rd_due_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic acc;
  logic go;
  logic [1:0] rd_lat;

  assign acc = psel && penable && !pready_reg;
  assign go = acc && pwrite && paddr == CMD_OFS && pwdata[CMD_GO_BIT] &&
    !busy_reg && !cfg_reg[CFG_SLEEP_BIT];
  // Read-due bit 0 is set on the command edge: index is latency less one
  assign rd_lat = cfg_reg[CFG_PIPE_BIT] ? 2'h1 : 2'h0;

  // ---------------------------------------------------------------
  // APB slave: answers one cycle into the access phase
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      cfg_reg <= CFG_RESET;
      wdata_reg <= '0;
    end else begin
      pready_reg <= acc;
      pslverr_reg <= 1'b0;
      if (acc) begin
        case (paddr)
          CMD_OFS: prdata_reg <= '0;
          WDATA_OFS: prdata_reg <= 32'(wdata_reg);
          RDATA_OFS: prdata_reg <= 32'(rdata_reg);
          CFG_OFS: prdata_reg <= 32'(cfg_reg);
          STATUS_OFS: prdata_reg <= {31'h0, busy_reg};
          default: begin
            prdata_reg <= '0;
            pslverr_reg <= 1'b1;
          end
        endcase
        if (pwrite && paddr == CFG_OFS && !busy_reg) begin
          cfg_reg <= pwdata[3:0];
        end
        if (pwrite && paddr == WDATA_OFS) begin
          wdata_reg <= pwdata[DATA_W-1:0];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      left_reg <= 2'h0;
      is_wr_reg <= 1'b0;
      pins.addr <= '0;
      pins.advance_load_n <= 1'b0;
      pins.chip_en_n <= 1'b1;
      pins.write_n <= 1'b1;
      pins.byte_wr_n <= '1;
      dly_reg <= '0;
    end else if (!cfg_reg[CFG_HOLD_BIT]) begin
      dly_reg <= (dly_reg != 4'h0) ? dly_reg - 4'h1 : 4'h0;
      if (go && !(pwdata[CMD_WR_BIT] && dly_reg != 4'h0)) begin
        busy_reg <= 1'b1;
        is_wr_reg <= pwdata[CMD_WR_BIT];
        left_reg <= pwdata[CMD_BURST_BIT] ? 2'(BURST_LEN - 1) : 2'h0;
        pins.addr <= pwdata[CMD_ADDR_POS +: ADDR_W];
        pins.advance_load_n <= 1'b0;
        pins.chip_en_n <= 1'b0;
        pins.write_n <= !pwdata[CMD_WR_BIT];
        pins.byte_wr_n <= ~pwdata[CMD_BE_POS +: BYTES];
      end else if (busy_reg && left_reg != 2'h0) begin
        pins.advance_load_n <= 1'b1;
        left_reg <= left_reg - 2'h1;
      end else begin
        busy_reg <= 1'b0;
        pins.advance_load_n <= 1'b0;
        pins.chip_en_n <= 1'b1;
        pins.write_n <= 1'b1;
      end
      if (cfg_reg[CFG_SLEEP_BIT]) begin
        dly_reg <= 4'(SLEEP_ENTRY_CYCLES + SLEEP_RECOVERY_CYCLES + 2);
      end
    end
  end

  // write data driven across the capture edge
  logic wr_beat;
  logic wr_sh_reg;
  assign wr_beat = busy_reg && is_wr_reg && !pins.chip_en_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_sh_reg <= 1'b0;
      rd_due_reg <= '0;
      rdata_reg <= '0;
      pins.dq_from_ctrl <= '0;
      pins.dq_ctrl_oe_n <= 1'b1;
    end else if (!cfg_reg[CFG_HOLD_BIT]) begin
      wr_sh_reg <= wr_beat;
      rd_due_reg <= {rd_due_reg[2:0],
        busy_reg && !is_wr_reg && !pins.chip_en_n};
      // Flow mode captures one edge after the command, pipelined two
      pins.dq_ctrl_oe_n <= !(cfg_reg[CFG_PIPE_BIT] ? wr_sh_reg : wr_beat);
      pins.dq_from_ctrl <= wdata_reg;
      if (rd_due_reg[rd_lat] && !pins.dq_ram_oe_n) begin
        rdata_reg <= pins.dq_from_ram;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins.sleep_request <= 1'b0;
      pins.clk_en_n <= 1'b0;
      pins.out_en_n <= 1'b0;
      pins.burst_order_select <= 1'b0;
      pins.output_register_select <= 1'b1;
    end else begin
      pins.sleep_request <= cfg_reg[CFG_SLEEP_BIT];
      pins.clk_en_n <= cfg_reg[CFG_HOLD_BIT];
      pins.out_en_n <= 1'b0;
      pins.burst_order_select <= cfg_reg[CFG_ORDER_BIT];
      pins.output_register_select <= cfg_reg[CFG_PIPE_BIT];
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
endmodule

// ==== hdl/sram_dev.sv ====
// Behavioural synchronous late-write SRAM with burst, mode pins and sleep.
// Assumes pins arrive from a controller on the same pclk.
`timescale 1ns/100ps
module sram_dev
  import sram_pkg::*;
#(
  parameter int DEPTH = 1 << ADDR_W
)
(
  input wire logic pclk,
  input wire logic presetn,
  sram_if.ram pins
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [1:0] zz_sync_reg;
  logic [1:0] sleep_cnt_reg;
  logic asleep_reg;
  logic [ADDR_W-1:2] upper_reg;
  logic burst_active_reg;
  logic [1:0] addr_lo;
  logic [ADDR_W-1:0] cur_addr;
  logic active;
  logic load;
  logic cont;
  logic ft_mode;
  logic [WR_LAT_PIPE-1:0] wr_pend_reg;
  logic [ADDR_W-1:0] wr_addr_reg [WR_LAT_PIPE];
  logic [BYTES-1:0] wr_be_reg [WR_LAT_PIPE];
  logic rd_cmd;
  logic [1:0] sleep_target;
  logic [DATA_W-1:0] q_reg;
  logic q_valid_reg;
  logic [DATA_W-1:0] dq_out_reg;
  logic dq_oe_n_reg;
  logic mode_pipe_reg;

  // ---------------------------------------------------------------
  // Sleep control
  // ---------------------------------------------------------------
  // synchronise asynchronous request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zz_sync_reg <= 2'h0;
    end else begin
      zz_sync_reg <= {zz_sync_reg[0], pins.sleep_request};
    end
  end

  // Entry and wake-up each have their own count; both start once
  // the request has crossed the synchroniser
  assign sleep_target = asleep_reg ? 2'(SLEEP_RECOVERY_CYCLES - 1) :
    2'(SLEEP_ENTRY_CYCLES - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_cnt_reg <= 2'h0;
      asleep_reg <= 1'b0;
    end else if (zz_sync_reg[1] != asleep_reg) begin
      if (sleep_cnt_reg == sleep_target) begin
        sleep_cnt_reg <= 2'h0;
        asleep_reg <= zz_sync_reg[1];
      end else begin
        sleep_cnt_reg <= sleep_cnt_reg + 2'h1;
      end
    end else begin
      sleep_cnt_reg <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  // sleep and hold gate every input but the mode and sleep pins
  assign active = !asleep_reg && !pins.clk_en_n;
  assign load = active && !pins.advance_load_n;
  assign cont = active && pins.advance_load_n && burst_active_reg;
  assign ft_mode = !mode_pipe_reg;

  // Mode pin is static; a flop keeps it off the combinational path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_pipe_reg <= 1'b1;
    end else begin
      mode_pipe_reg <= pins.output_register_select;
    end
  end

  burst_addr_gen u_burst (
    .pclk(pclk),
    .presetn(presetn),
    .load(load),
    .step(cont),
    .interleave(pins.burst_order_select),
    .start(pins.addr[1:0]),
    .addr_lo(addr_lo)
  );

  // load upper bits, burst needs selected start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upper_reg <= '0;
      burst_active_reg <= 1'b0;
    end else if (load) begin
      upper_reg <= pins.addr[ADDR_W-1:2];
      burst_active_reg <= !pins.chip_en_n;
    end
  end

  // counter drives only two low bits
  assign cur_addr = load ? pins.addr : {upper_reg, addr_lo};

  // ---------------------------------------------------------------
  // Late write pipeline
  // ---------------------------------------------------------------
  // write data taken two or one edges later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_pend_reg <= '0;
      for (int i = 0; i < WR_LAT_PIPE; i++) begin
        wr_addr_reg[i] <= '0;
        wr_be_reg[i] <= '0;
      end
    end else if (active) begin
      // A write abort still takes its slot, with no byte lane set
      wr_pend_reg[0] <= !pins.write_n && (cont || (load && !pins.chip_en_n));
      wr_addr_reg[0] <= cur_addr;
      wr_be_reg[0] <= ~pins.byte_wr_n;
      wr_pend_reg[1] <= ft_mode ? 1'b0 : wr_pend_reg[0];
      wr_addr_reg[1] <= wr_addr_reg[0];
      wr_be_reg[1] <= wr_be_reg[0];
    end
  end

  always_ff @(posedge pclk) begin
    if (active) begin
      for (int b = 0; b < BYTES; b++) begin
        if (ft_mode && wr_pend_reg[0] && wr_be_reg[0][b]) begin
          mem[wr_addr_reg[0]][b*8 +: 8] <= pins.dq_from_ctrl[b*8 +: 8];
        end else if (!ft_mode && wr_pend_reg[1] && wr_be_reg[1][b]) begin
          mem[wr_addr_reg[1]][b*8 +: 8] <= pins.dq_from_ctrl[b*8 +: 8];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // flow reads drive the pins from the command edge, pipelined
  // reads one edge later through q_reg
  assign rd_cmd = pins.write_n && (cont || (load && !pins.chip_en_n));

  // A read of a word whose late write is still pending sees old data;
  // the status poll between commands keeps that pair apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_reg <= '0;
      q_valid_reg <= 1'b0;
    end else if (active) begin
      q_reg <= mem[cur_addr];
      q_valid_reg <= rd_cmd && !ft_mode;
    end
  end

  // outputs off while asleep; pipeline adds the output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_out_reg <= '0;
      dq_oe_n_reg <= 1'b1;
    end else if (asleep_reg || zz_sync_reg[1]) begin
      dq_oe_n_reg <= 1'b1;
    end else if (active) begin
      // a hold keeps the bus as it was, driven or not
      dq_out_reg <= ft_mode ? mem[cur_addr] : q_reg;
      dq_oe_n_reg <= !(ft_mode ? rd_cmd : q_valid_reg) ||
        pins.out_en_n;
    end
  end

  assign pins.dq_from_ram = dq_out_reg;
  assign pins.dq_ram_oe_n = dq_oe_n_reg;
endmodule

// ==== hdl/sram_if.sv ====
// Synchronous pins between the SRAM and its controller.
// Assumes the bench resolves the data bus from the two output enables.
`timescale 1ns/100ps
interface sram_if import sram_pkg::*; ();
  logic [ADDR_W-1:0] addr;
  logic advance_load_n;
  logic chip_en_n;
  logic write_n;
  logic [BYTES-1:0] byte_wr_n;
  logic clk_en_n;
  logic out_en_n;
  logic burst_order_select;
  logic output_register_select;
  logic sleep_request;
  logic [DATA_W-1:0] dq_from_ctrl;
  logic dq_ctrl_oe_n;
  logic [DATA_W-1:0] dq_from_ram;
  logic dq_ram_oe_n;
  modport ram (input addr, advance_load_n, chip_en_n, write_n, byte_wr_n,
    clk_en_n, out_en_n, burst_order_select, output_register_select,
    sleep_request, dq_from_ctrl, dq_ctrl_oe_n,
    output dq_from_ram, dq_ram_oe_n);
  modport ctrl (output addr, advance_load_n, chip_en_n, write_n, byte_wr_n,
    clk_en_n, out_en_n, burst_order_select, output_register_select,
    sleep_request, dq_from_ctrl, dq_ctrl_oe_n,
    input dq_from_ram, dq_ram_oe_n);
endinterface

// ==== hdl/sram_pkg.sv ====
// Shared constants and types for the synchronous late-write SRAM pair.
// Assumes one clock (pclk, 10 MHz) feeding both ends.
package sram_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int BYTES = 2;
  localparam int BURST_LEN = 4;
  localparam logic [1:0] BURST_START_CNT = 2'h0;
  // Sleep entry and wake-up, in clock cycles
  localparam int SLEEP_ENTRY_CYCLES = 2;
  localparam int SLEEP_RECOVERY_CYCLES = 2;
  // Write data capture edge after the command edge
  localparam int WR_LAT_PIPE = 2;
  localparam int WR_LAT_FLOW = 1;
  // APB register offsets of the controller
  localparam logic [7:0] CMD_OFS = 8'h00;
  localparam logic [7:0] WDATA_OFS = 8'h04;
  localparam logic [7:0] RDATA_OFS = 8'h08;
  localparam logic [7:0] CFG_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // Command and config register fields
  localparam int CMD_GO_BIT = 31;
  localparam int CMD_WR_BIT = 30;
  localparam int CMD_BURST_BIT = 29;
  localparam int CMD_BE_POS = 16;
  localparam int CMD_ADDR_POS = 0;
  localparam int CFG_ORDER_BIT = 0;
  localparam int CFG_PIPE_BIT = 1;
  localparam int CFG_SLEEP_BIT = 2;
  localparam int CFG_HOLD_BIT = 3;
  localparam logic [3:0] CFG_RESET = 4'h2;
  typedef enum logic [1:0] {CMD_DESEL, CMD_READ, CMD_WRITE, CMD_BURST} cmd_t;
endpackage
